// ---- rtl/ibc_device_end.sv ----
// Device end: bus conditions, address match, acknowledge and hold-time logic.
// Assumes the far end clocks the bus; user-side controls come from core logic.
`include "ibc_consts.svh"
module ibc_device_end (
  ibc_bus_if.device         bus,                       // Two-wire bus
  input  wire logic         CORE_CLK_I,                // 50 MHz core clock
  input  wire logic         RST_I,                     // Async reset, high
  input  wire logic         PORT_ENABLE_BIT_I,         // Port enabled in two-wire mode
  input  wire logic         LONG_HOLD_SELECT_I,        // Long data hold after clock fall
  input  wire logic         TEN_BIT_MODE_I,            // Ten-bit addressing
  input  wire logic         MODE_HAS_SP_IRQ_I,         // Mode already flags start/stop
  input  wire logic         START_IRQ_ENABLE_I,        // Extra start interrupt
  input  wire logic         STOP_IRQ_ENABLE_I,         // Extra stop interrupt
  input  wire logic         ADDRESS_HOLD_ENABLE_I,     // Software acks address
  input  wire logic         DATA_HOLD_ENABLE_I,        // Software acks data
  input  wire logic         ACK_VALUE_SELECT_I,        // Ack level, 1 = not acked
  input  wire logic         BUFFER_FULL_FLAG_I,        // Receive buffer full
  input  wire logic         RECEIVE_OVERFLOW_FLAG_I,   // Receive overflow
  input  ibc_pkg::ibc_addr_t OWN_ADDRESS_REG_I,        // Own address
  input  wire logic         RELEASE_I,                 // Pulse: release held clock
  input  ibc_pkg::ibc_byte_t TX_DATA_I,                // Byte to send, taken at release
  input  wire logic         GEN_START_I,               // Level: issue start
  input  wire logic         COLLISION_CLR_I,           // Pulse: clear collision
  output logic              BUS_IDLE_O,                // Bus idle
  output logic              START_EVT_O,               // Pulse: start or restart seen
  output logic              STOP_EVT_O,                // Pulse: stop seen
  output logic              COND_IRQ_O,                // Pulse: enabled start/stop event
  output logic              COLLISION_O,               // Sticky collision
  output logic              ACK_RESULT_FLAG_O,         // Ack level from receiver
  output logic              ACK_TIME_FLAG_O,           // Acknowledge time
  output logic              PRIOR_MATCH_O,             // Ten-bit prior match
  output logic              ADDRESSED_O,               // Addressed, receive or send
  output logic              READ_MODE_O,               // Addressed for read
  output logic              CLOCK_HELD_O,              // Clock stretched
  output ibc_pkg::ibc_byte_t RX_BYTE_O,                // Received byte
  output logic              RX_VALID_O                 // Pulse: byte received and acked
);
  import ibc_pkg::*;

  localparam logic [3:0] LONG_HOLD  = 4'(`IBC_HOLD_CYC(`IBC_LONG_HOLD_NS));
  localparam logic [3:0] SHORT_HOLD = 4'(`IBC_HOLD_CYC(`IBC_SHORT_HOLD_NS));

  logic        scl_s, scl_rise, scl_fall;
  logic        sda_s, sda_rise, sda_fall;
  logic        start_det, stop_det, tx_lost, hold_en, ack_lvl_c, drive_c;
  logic        take_c, prior_c, gen_req;
  ibc_slv_st_t st_q, nxt_c;
  logic [3:0]  bit_q, hold_q;
  ibc_byte_t   shift_q, tx_q, rx_byte_q;
  logic        want_q, ack_rx_q, ovf_q, stretch_q, prior_q, ack_res_q, ack_time_q;
  logic        rw_q, rx_valid_q, busy_q, seen_low_q, idle_q, dat_oe_q, sda_oe_q, scl_oe_q;
  logic        start_q, stop_q, irq_q, gen_prev_q, pull_q, coll_q, addressed_q;
  logic        data_q, hold_scl;
  logic [1:0]  rel_q;

  ibc_line_sync u_scl (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .line_i  (bus.scl),
    .level_o (scl_s),
    .rise_o  (scl_rise),
    .fall_o  (scl_fall)
  );
  ibc_line_sync u_sda (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .line_i  (bus.sda),
    .level_o (sda_s),
    .rise_o  (sda_rise),
    .fall_o  (sda_fall)
  );

  assign start_det = sda_fall & scl_s;
  assign stop_det  = sda_rise & scl_s & seen_low_q;
  assign hold_en   = ADDRESS_HOLD_ENABLE_I | DATA_HOLD_ENABLE_I;
  assign tx_lost   = scl_rise & (st_q == IBC_TX) & (bit_q != `IBC_ACK_SLOT) & ~want_q & ~sda_s;
  assign ack_lvl_c = ovf_q | (hold_en & ACK_VALUE_SELECT_I);
  assign drive_c   = ack_rx_q ? ~ack_lvl_c : want_q;
  assign gen_req   = GEN_START_I & ~gen_prev_q;
  // clock held while data may still move
  assign hold_scl  = stretch_q | ((addressed_q | ack_rx_q) & (hold_q != '0));

  // Outcome of a byte at its eighth clock fall
  always_comb begin
    nxt_c   = st_q;
    take_c  = 1'b0;
    prior_c = prior_q;
    case (st_q)
      IBC_ADDR: begin
        if (TEN_BIT_MODE_I) begin
          if (shift_q[`IBC_BYTE_MSB:1] == {`IBC_TEN_HI, OWN_ADDRESS_REG_I[9:8]}) begin
            if (!shift_q[0]) begin
              nxt_c   = IBC_ADDR_LO;
              take_c  = 1'b1;
              prior_c = 1'b0;
            end else if (prior_q) begin
              nxt_c  = IBC_TX;
              take_c = 1'b1;
            end else begin
              nxt_c = IBC_SKIP;
            end
          end else begin
            nxt_c   = IBC_SKIP;
            prior_c = 1'b0;
          end
        end else if (shift_q[`IBC_BYTE_MSB:1] == OWN_ADDRESS_REG_I[6:0]) begin
          nxt_c  = shift_q[0] ? IBC_TX : IBC_RX;
          take_c = 1'b1;
        end else begin
          nxt_c = IBC_SKIP;
        end
      end
      IBC_ADDR_LO: begin
        if (shift_q == OWN_ADDRESS_REG_I[7:0]) begin
          nxt_c   = IBC_RX;
          take_c  = 1'b1;
          prior_c = 1'b1;
        end else begin
          nxt_c = IBC_SKIP;
        end
      end
      IBC_RX:  take_c = 1'b1;
      default: nxt_c = st_q;
    endcase
  end

  // Byte sequencing, acknowledge and transmit
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= IBC_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      want_q <= 1'b0;
      ack_rx_q <= 1'b0;
      ovf_q <= 1'b0;
      stretch_q <= 1'b0;
      prior_q <= 1'b0;
      ack_res_q <= 1'b0;
      ack_time_q <= 1'b0;
      rw_q <= 1'b0;
      rx_byte_q <= '0;
      data_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end else if (!PORT_ENABLE_BIT_I || start_det || stop_det) begin
      st_q <= start_det && PORT_ENABLE_BIT_I ? IBC_ADDR : IBC_IDLE;
      bit_q <= '0;
      want_q <= 1'b0;
      ack_rx_q <= 1'b0;
      stretch_q <= 1'b0;
      ack_time_q <= 1'b0;
      rx_valid_q <= 1'b0;
      if (!start_det) begin
        prior_q <= 1'b0;
      end
    end else begin
      rx_valid_q <= 1'b0;
      if (stretch_q && RELEASE_I) begin
        stretch_q <= 1'b0;
        if (st_q == IBC_TX && bit_q == '0) begin
          tx_q <= TX_DATA_I;
          want_q <= ~TX_DATA_I[`IBC_BYTE_MSB];
        end
      end
      if (scl_rise && st_q != IBC_IDLE && st_q != IBC_SKIP) begin
        if (bit_q != `IBC_ACK_SLOT) begin
          shift_q <= {shift_q[6:0], sda_s};
        end else if (st_q == IBC_TX && !ack_rx_q) begin
          ack_res_q <= sda_s;
        end
        if (tx_lost) begin
          st_q <= IBC_SKIP;
          want_q <= 1'b0;
        end
      end
      // First fall after a start ends the start, not a bit
      if (scl_fall && seen_low_q && st_q != IBC_IDLE && st_q != IBC_SKIP) begin
        if (bit_q == `IBC_LAST_BIT) begin
          st_q <= nxt_c;
          prior_q <= prior_c;
          ack_rx_q <= take_c;
          ovf_q <= BUFFER_FULL_FLAG_I | RECEIVE_OVERFLOW_FLAG_I;
          want_q <= 1'b0;
          ack_time_q <= take_c & hold_en;
          stretch_q <= take_c & hold_en;
          bit_q <= `IBC_ACK_SLOT;
          data_q <= (st_q == IBC_RX);
          if (st_q == IBC_ADDR) begin
            rw_q <= shift_q[0];
          end
          if (st_q == IBC_RX) begin
            rx_byte_q <= shift_q;
          end
        end else if (bit_q == `IBC_ACK_SLOT) begin
          ack_rx_q <= 1'b0;
          ack_time_q <= 1'b0;
          bit_q <= '0;
          rx_valid_q <= ack_rx_q & ~ack_lvl_c & data_q;
          if (ack_rx_q && ack_lvl_c) begin
            st_q <= IBC_SKIP;
          end else if (st_q == IBC_TX) begin
            if (ack_rx_q || !ack_res_q) begin
              stretch_q <= 1'b1;
            end else begin
              st_q <= IBC_SKIP;
            end
          end
        end else begin
          bit_q <= bit_q + 4'h1;
          if (st_q == IBC_TX) begin
            tx_q <= {tx_q[6:0], 1'b0};
            want_q <= ~tx_q[6];
          end
        end
      end
    end
  end

  // Bus state and condition events
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
      seen_low_q <= 1'b0;
      idle_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (start_det) begin
        busy_q <= 1'b1;
        seen_low_q <= 1'b0;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end else if (scl_fall) begin
        seen_low_q <= 1'b1;
      end
      idle_q <= ~busy_q & scl_s & sda_s;
      start_q <= start_det;
      stop_q <= stop_det;
      irq_q <= (start_det & (MODE_HAS_SP_IRQ_I | START_IRQ_ENABLE_I))
             | (stop_det & (MODE_HAS_SP_IRQ_I | STOP_IRQ_ENABLE_I));
    end
  end

  // Start generation and collision flag; a set beats a clear
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gen_prev_q <= 1'b0;
      pull_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      gen_prev_q <= GEN_START_I;
      if (!GEN_START_I || !PORT_ENABLE_BIT_I) begin
        pull_q <= 1'b0;
      end else if (gen_req && sda_s) begin
        pull_q <= 1'b1;
      end
      if ((gen_req && !sda_s) || tx_lost) begin
        coll_q <= 1'b1;
      end else if (COLLISION_CLR_I) begin
        coll_q <= 1'b0;
      end
    end
  end

  // Pin drive; data changes wait out the hold after each clock fall
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_q <= '0;
      dat_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
      addressed_q <= 1'b0;
      rel_q <= '0;
    end else begin
      if (scl_fall) begin
        hold_q <= LONG_HOLD_SELECT_I ? LONG_HOLD : SHORT_HOLD;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 4'h1;
      end else begin
        dat_oe_q <= drive_c;
      end
      sda_oe_q <= PORT_ENABLE_BIT_I & (pull_q | dat_oe_q);
      // Two extra cycles so a new data level is on the wire before clock rises
      rel_q <= {rel_q[0], hold_scl};
      scl_oe_q <= PORT_ENABLE_BIT_I & (hold_scl | (rel_q != 2'h0));
      addressed_q <= (st_q == IBC_RX) | (st_q == IBC_TX);
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;
  assign bus.dev_scl_oe = scl_oe_q;

  assign BUS_IDLE_O        = idle_q;
  assign START_EVT_O       = start_q;
  assign STOP_EVT_O        = stop_q;
  assign COND_IRQ_O        = irq_q;
  assign COLLISION_O       = coll_q;
  assign ACK_RESULT_FLAG_O = ack_res_q;
  assign ACK_TIME_FLAG_O   = ack_time_q;
  assign PRIOR_MATCH_O     = prior_q;
  assign ADDRESSED_O       = addressed_q;
  assign READ_MODE_O       = rw_q;
  assign CLOCK_HELD_O      = stretch_q;
  assign RX_BYTE_O         = rx_byte_q;
  assign RX_VALID_O        = rx_valid_q;
endmodule : ibc_device_end

// ---- include/ibc_consts.svh ----
// Shared constants for the two-wire bus-condition and acknowledge logic.
// Assumes a single 50 MHz core clock on both ends and an open-drain bus.
`ifndef IBC_CONSTS_SVH
`define IBC_CONSTS_SVH
`define IBC_CLK_NS        20
`define IBC_LONG_HOLD_NS  300
`define IBC_SHORT_HOLD_NS 100
`define IBC_HOLD_CYC(ns)  (((ns) + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_LINE_IDLE     1'b1
`define IBC_BYTE_MSB      7
`define IBC_LAST_BIT      4'h7
`define IBC_ACK_SLOT      4'h8
`define IBC_TEN_HI        5'h1e
`define IBC_QTR_CYC       4
`define IBC_REG_CMD       8'h00
`define IBC_REG_DATA      8'h04
`define IBC_REG_STAT      8'h08
`define IBC_CMD_START     2'h1
`define IBC_CMD_BYTE      2'h2
`define IBC_CMD_STOP      2'h3
`define IBC_CMD_ACK_POS   8
`define IBC_CMD_READ_POS  9
`endif

// ---- include/ibc_pkg.sv ----
// Types shared by both ends of the two-wire link.
// Assumes ibc_consts.svh for all numeric constants.
package ibc_pkg;
  typedef logic [7:0] ibc_byte_t;
  typedef logic [9:0] ibc_addr_t;
  typedef enum logic [2:0] {IBC_IDLE, IBC_ADDR, IBC_ADDR_LO, IBC_RX, IBC_TX, IBC_SKIP} ibc_slv_st_t;
  typedef enum logic [1:0] {IBC_M_IDLE, IBC_M_START, IBC_M_BYTE, IBC_M_STOP} ibc_mst_st_t;
endpackage : ibc_pkg

// ---- include/ibc_bus_if.sv ----
// Two-wire bus carrier joining the device end and the host end.
// Both lines are wired-AND with pull-up: a line is low while any enable is high.
interface ibc_bus_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic hst_scl_o;
  logic hst_scl_oe;
  logic hst_sda_o;
  logic hst_sda_oe;
  logic scl;
  logic sda;

  assign scl = ~(dev_scl_oe | hst_scl_oe);
  assign sda = ~(dev_sda_oe | hst_sda_oe);

  modport device (input scl, input sda,
                  output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport host   (input scl, input sda,
                  output hst_scl_o, output hst_scl_oe, output hst_sda_o, output hst_sda_oe);
endinterface : ibc_bus_if

// ---- rtl/ibc_line_sync.sv ----
// Two-flop synchroniser for one bus line, with edge detection.
// Assumes the line is asynchronous to clk_i and idles high.
`include "ibc_consts.svh"
module ibc_line_sync (
  input  wire logic clk_i,    // Core clock
  input  wire logic rst_i,    // Async reset, high
  input  wire logic line_i,   // Raw bus line
  output logic      level_o,  // Synchronised level
  output logic      rise_o,   // One-cycle rising pulse
  output logic      fall_o    // One-cycle falling pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= `IBC_LINE_IDLE;
      sync_q <= `IBC_LINE_IDLE;
      last_q <= `IBC_LINE_IDLE;
    end else begin
      meta_q <= line_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;
endmodule : ibc_line_sync

// ---- rtl/ibc_host_end.sv ----
// Host end: bus master driven by commands written over AHB-Lite.
// Assumes one master on the AHB side; the clock line is made by a divider here.
`include "ibc_consts.svh"
module ibc_host_end #(
  parameter int QTR_CYC = `IBC_QTR_CYC        // Core cycles per quarter bit
) (
  ibc_bus_if.host           bus,               // Two-wire bus
  input  wire logic         CORE_CLK_I,        // 50 MHz core clock
  input  wire logic         RST_I,             // Async reset, high
  input  wire logic         HSEL_I,            // AHB select
  input  wire logic [31:0]  HADDR_I,           // AHB address
  input  wire logic [1:0]   HTRANS_I,          // AHB transfer type
  input  wire logic         HWRITE_I,          // AHB write
  input  wire logic [2:0]   HSIZE_I,           // AHB size, word only
  input  wire logic [31:0]  HWDATA_I,          // AHB write data
  input  wire logic         HREADY_I,          // AHB bus ready
  output logic              HREADYOUT_O,       // AHB slave ready
  output logic [31:0]       HRDATA_O,          // AHB read data
  output logic              HRESP_O            // AHB response, always OKAY
);
  import ibc_pkg::*;

  logic        scl_s, sda_s, ap, tick;
  logic        ap_wr_q, rdp_q, hready_q, scl_oe_q, sda_oe_q, rd_q, ack_q, ack_in_q;
  logic [7:0]  ap_addr_q;
  logic [31:0] hrdata_q, rd_mux;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  qcnt_q;
  ibc_byte_t   tx_q, rx_q;
  ibc_mst_st_t st_q;

  ibc_line_sync u_scl (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .line_i  (bus.scl),
    .level_o (scl_s),
    .rise_o  (),
    .fall_o  ()
  );
  ibc_line_sync u_sda (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .line_i  (bus.sda),
    .level_o (sda_s),
    .rise_o  (),
    .fall_o  ()
  );

  assign ap   = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign tick = qcnt_q == 8'(QTR_CYC - 1);

  always_comb begin
    case (ap_addr_q)
      `IBC_REG_DATA: rd_mux = {24'h0, rx_q};
      `IBC_REG_STAT: rd_mux = {28'h0, sda_s, scl_s, ack_in_q, st_q != IBC_M_IDLE};
      default:       rd_mux = 32'h0;
    endcase
  end

  // Writes complete with no wait; reads take one wait state
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= '0;
      rdp_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= '0;
    end else begin
      ap_wr_q <= ap & HWRITE_I;
      if (ap) begin
        ap_addr_q <= HADDR_I[7:0];
      end
      if (ap && !HWRITE_I) begin
        rdp_q <= 1'b1;
        hready_q <= 1'b0;
      end else if (rdp_q) begin
        rdp_q <= 1'b0;
        hready_q <= 1'b1;
        hrdata_q <= rd_mux;
      end
    end
  end

  // Quarter-bit divider
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      qcnt_q <= '0;
    end else begin
      qcnt_q <= tick ? 8'h0 : qcnt_q + 8'h1;
    end
  end

  // Command engine; commands written while busy are dropped
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= IBC_M_IDLE;
      ph_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      ack_in_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        IBC_M_IDLE: begin
          ph_q <= '0;
          bit_q <= '0;
          if (ap_wr_q && ap_addr_q == `IBC_REG_DATA) begin
            tx_q <= HWDATA_I[7:0];
          end
          if (ap_wr_q && ap_addr_q == `IBC_REG_CMD) begin
            rd_q <= HWDATA_I[`IBC_CMD_READ_POS];
            ack_q <= HWDATA_I[`IBC_CMD_ACK_POS];
            case (HWDATA_I[1:0])
              `IBC_CMD_START: st_q <= IBC_M_START;
              `IBC_CMD_BYTE:  st_q <= IBC_M_BYTE;
              `IBC_CMD_STOP:  st_q <= IBC_M_STOP;
              default:        st_q <= IBC_M_IDLE;
            endcase
          end
        end
        default: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin
                if (st_q == IBC_M_START) begin
                  sda_oe_q <= 1'b0;
                end else if (st_q == IBC_M_STOP) begin
                  sda_oe_q <= 1'b1;
                end else if (bit_q == `IBC_ACK_SLOT) begin
                  sda_oe_q <= rd_q & ack_q;
                end else begin
                  sda_oe_q <= ~rd_q & ~tx_q[`IBC_BYTE_MSB];
                end
              end
              2'h1: begin
                // Waits while a far end stretches the clock
                scl_oe_q <= 1'b0;
                if (!scl_s) begin
                  ph_q <= ph_q;
                end
              end
              2'h2: begin
                if (st_q == IBC_M_START) begin
                  sda_oe_q <= 1'b1;
                end else if (st_q == IBC_M_STOP) begin
                  sda_oe_q <= 1'b0;
                  st_q <= IBC_M_IDLE;
                end else if (bit_q == `IBC_ACK_SLOT) begin
                  ack_in_q <= sda_s;
                end else begin
                  rx_q <= {rx_q[6:0], sda_s};
                  tx_q <= {tx_q[6:0], 1'b0};
                end
              end
              default: begin
                scl_oe_q <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (st_q == IBC_M_START || bit_q == `IBC_ACK_SLOT) begin
                  st_q <= IBC_M_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign bus.hst_sda_o = 1'b0;
  assign bus.hst_scl_o = 1'b0;
  assign bus.hst_sda_oe = sda_oe_q;
  assign bus.hst_scl_oe = scl_oe_q;

  assign HREADYOUT_O = hready_q;
  assign HRDATA_O    = hrdata_q;
  assign HRESP_O     = 1'b0;
endmodule : ibc_host_end

// ---- testbench/ibc_checker.sv ----
// Wire-level assertions on the carrier between the two ends.
// Assumes the bench core clock and async high reset; inputs mirror the carrier.
module ibc_checker (
  input wire logic CORE_CLK_I, // Core clock
  input wire logic RST_I,      // Async reset, high
  input wire logic dev_scl_o,  // Device clock out
  input wire logic dev_scl_oe, // Device clock pull
  input wire logic dev_sda_o,  // Device data out
  input wire logic dev_sda_oe, // Device data pull
  input wire logic hst_scl_o,  // Host clock out
  input wire logic hst_scl_oe, // Host clock pull
  input wire logic hst_sda_o,  // Host data out
  input wire logic hst_sda_oe, // Host data pull
  input wire logic scl,        // Clock wire
  input wire logic sda         // Data wire
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_fall; $fell(scl); endsequence
  sequence s_hold; $stable(dev_sda_oe) [*5]; endsequence
  a_dev_scl_zero: assert property (dev_scl_o == 1'b0)
    else $error("device clock driven high");
  a_hst_scl_zero: assert property (hst_scl_o == 1'b0)
    else $error("host clock driven high");
  a_dev_sda_zero: assert property (dev_sda_o == 1'b0)
    else $error("device data value not zero");
  a_hst_sda_zero: assert property (hst_sda_o == 1'b0)
    else $error("host data value not zero");
  a_dev_hold_time: assert property (s_fall |=> s_hold)
    else $error("device data changed inside hold");
  a_dev_data_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed with clock high");
  a_start_then_low: assert property ($rose(hst_sda_oe) && scl |-> ##[1:16] !scl)
    else $error("clock not pulled after start");
  a_stop_stays_free: assert property ($fell(hst_sda_oe) && scl |=> sda [*2])
    else $error("data pulled right after stop");
endmodule : ibc_checker

// ---- testbench/testbench.sv ----
// Bench joining device end and host end; host commanded over AHB-Lite.
// Assumes one bus carrier and one core clock for both ends.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ibc_pkg::*;
  logic CORE_CLK_I = 0, RST_I = 1, PORT_ENABLE_BIT_I = 1, LONG_HOLD_SELECT_I = 0;
  logic TEN_BIT_MODE_I = 0, MODE_HAS_SP_IRQ_I = 0, START_IRQ_ENABLE_I = 1, STOP_IRQ_ENABLE_I = 1;
  logic ADDRESS_HOLD_ENABLE_I = 0, DATA_HOLD_ENABLE_I = 0, ACK_VALUE_SELECT_I = 0;
  logic BUFFER_FULL_FLAG_I = 0, RECEIVE_OVERFLOW_FLAG_I = 0, RELEASE_I = 0;
  logic GEN_START_I = 0, COLLISION_CLR_I = 0, HWRITE_I = 0, HREADYOUT_O, HRESP_O;
  ibc_addr_t OWN_ADDRESS_REG_I = 10'h02a;
  ibc_byte_t TX_DATA_I = 8'h00, RX_BYTE_O;
  logic BUS_IDLE_O, START_EVT_O, STOP_EVT_O, COND_IRQ_O, COLLISION_O, ACK_RESULT_FLAG_O;
  logic ACK_TIME_FLAG_O, PRIOR_MATCH_O, ADDRESSED_O, READ_MODE_O, CLOCK_HELD_O, RX_VALID_O;
  logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O, rd;
  logic [1:0] HTRANS_I = 0;
  int err_count, compares, cyc, n_evt, n_irq, n_rxv;
  ibc_bus_if bus ();
  ibc_device_end ibc_device_end_i (.bus, .CORE_CLK_I, .RST_I, .PORT_ENABLE_BIT_I,
    .LONG_HOLD_SELECT_I, .TEN_BIT_MODE_I, .MODE_HAS_SP_IRQ_I, .START_IRQ_ENABLE_I,
    .STOP_IRQ_ENABLE_I, .ADDRESS_HOLD_ENABLE_I, .DATA_HOLD_ENABLE_I, .ACK_VALUE_SELECT_I,
    .BUFFER_FULL_FLAG_I, .RECEIVE_OVERFLOW_FLAG_I, .OWN_ADDRESS_REG_I, .RELEASE_I, .TX_DATA_I,
    .GEN_START_I, .COLLISION_CLR_I, .BUS_IDLE_O, .START_EVT_O, .STOP_EVT_O, .COND_IRQ_O,
    .COLLISION_O, .ACK_RESULT_FLAG_O, .ACK_TIME_FLAG_O, .PRIOR_MATCH_O, .ADDRESSED_O,
    .READ_MODE_O, .CLOCK_HELD_O, .RX_BYTE_O, .RX_VALID_O);
  // Quarter of 12 keeps clock low longer than the long hold
  ibc_host_end #(.QTR_CYC(12)) ibc_host_end_i (.bus, .CORE_CLK_I, .RST_I, .HSEL_I(1'b1),
    .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I(3'h2), .HWDATA_I, .HREADY_I(HREADYOUT_O),
    .HREADYOUT_O, .HRDATA_O, .HRESP_O);
  ibc_checker ibc_checker_i (.CORE_CLK_I, .RST_I, .dev_scl_o(bus.dev_scl_o),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe),
    .hst_scl_o(bus.hst_scl_o), .hst_scl_oe(bus.hst_scl_oe), .hst_sda_o(bus.hst_sda_o),
    .hst_sda_oe(bus.hst_sda_oe), .scl(bus.scl), .sda(bus.sda));
  always #10 CORE_CLK_I = ~CORE_CLK_I;
  task complete_run;
    $display("TB: compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge CORE_CLK_I) begin
    cyc++;
    n_evt += START_EVT_O + STOP_EVT_O;
    n_irq += COND_IRQ_O;
    n_rxv += RX_VALID_O;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HTRANS_I <= 2'h2;
    HADDR_I <= {24'h0, a};
    HWRITE_I <= w;
    @(posedge CORE_CLK_I);
    while (HREADYOUT_O !== 1'b1) @(posedge CORE_CLK_I);
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    @(posedge CORE_CLK_I);
    while (HREADYOUT_O !== 1'b1) @(posedge CORE_CLK_I);
    rd = HRDATA_O;
  endtask : ahb
  task run(input logic [31:0] c);
    ahb(1'b1, 8'h00, c);
    do ahb(1'b0, 8'h08, 32'h0); while (rd[0] !== 1'b0);
  endtask : run
  task send(input logic [7:0] b);
    ahb(1'b1, 8'h04, {24'h0, b});
    run(32'h2);
  endtask : send
  task release_clk;
    while (CLOCK_HELD_O !== 1'b1) @(posedge CORE_CLK_I);
    RELEASE_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RELEASE_I <= 1'b0;
  endtask : release_clk
  initial begin
    repeat (2) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    @(posedge CORE_CLK_I);
    run(32'h1);
    // Host still holds data low after its start
    GEN_START_I <= 1'b1;
    repeat (6) @(posedge CORE_CLK_I);
    chk(COLLISION_O, 1, "start collision");
    GEN_START_I <= 1'b0;
    COLLISION_CLR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    COLLISION_CLR_I <= 1'b0;
    @(posedge CORE_CLK_I);
    chk(COLLISION_O, 0, "collision cleared");
    send(8'h54);
    chk(rd[1], 0, "address ack");
    send(8'ha5);
    chk(rd[1], 0, "data ack");
    chk(RX_BYTE_O, 8'ha5, "rx byte");
    run(32'h3);
    repeat (4) @(posedge CORE_CLK_I);
    chk(BUS_IDLE_O, 1, "idle");
    chk(n_evt, 2, "events");
    chk(n_irq, 2, "irqs");
    chk(n_rxv, 1, "rx valid");
    $display("TB: write test done");
    run(32'h1);
    send(8'h56);
    chk(rd[1], 1, "foreign address");
    BUFFER_FULL_FLAG_I <= 1'b1;
    run(32'h1);
    send(8'h54);
    chk(rd[1], 1, "full after restart");
    BUFFER_FULL_FLAG_I <= 1'b0;
    run(32'h3);
    $display("TB: refusal test done");
    ADDRESS_HOLD_ENABLE_I <= 1'b1;
    ACK_VALUE_SELECT_I <= 1'b1;
    run(32'h1);
    ahb(1'b1, 8'h04, 32'h54);
    ahb(1'b1, 8'h00, 32'h2);
    while (ACK_TIME_FLAG_O !== 1'b1) @(posedge CORE_CLK_I);
    chk(CLOCK_HELD_O, 1, "held at ack");
    release_clk();
    do ahb(1'b0, 8'h08, 32'h0); while (rd[0] !== 1'b0);
    chk(rd[1], 1, "software nack");
    ADDRESS_HOLD_ENABLE_I <= 1'b0;
    ACK_VALUE_SELECT_I <= 1'b0;
    run(32'h3);
    $display("TB: hold test done");
    TEN_BIT_MODE_I <= 1'b1;
    run(32'h1);
    send(8'hf0);
    chk(rd[1], 0, "high byte ack");
    send(8'h2a);
    chk(PRIOR_MATCH_O, 1, "prior match");
    chk(ADDRESSED_O, 1, "addressed");
    run(32'h3);
    repeat (4) @(posedge CORE_CLK_I);
    chk(PRIOR_MATCH_O, 0, "prior cleared");
    TEN_BIT_MODE_I <= 1'b0;
    $display("TB: ten-bit test done");
    LONG_HOLD_SELECT_I <= 1'b1;
    run(32'h1);
    send(8'h55);
    chk(READ_MODE_O, 1, "read mode");
    TX_DATA_I <= 8'h3c;
    release_clk();
    run(32'h202);
    chk(ACK_RESULT_FLAG_O, 1, "nack captured");
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h3c, "read byte");
    run(32'h3);
    $display("TB: read test done");
    complete_run();
  end
endmodule : testbench
